// File: rtl/sdc_pkg.sv
package sdc_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses on the APB side)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SENSOR_CONTROL   = 8'h00;
	localparam logic [7:0] ADDR_ONE_OFFSET_LOW   = 8'h04;
	localparam logic [7:0] ADDR_ONE_OFFSET_HIGH  = 8'h08;
	localparam logic [7:0] ADDR_TWO_OFFSET_LOW   = 8'h0C;
	localparam logic [7:0] ADDR_TWO_OFFSET_HIGH  = 8'h10;
	localparam logic [7:0] ADDR_ONE_GAIN         = 8'h14;
	localparam logic [7:0] ADDR_TWO_GAIN         = 8'h18;
	localparam logic [7:0] ADDR_DECIMATOR_CTRL   = 8'h1C;
	localparam logic [7:0] ADDR_LOAD_REQUEST     = 8'h20;
	localparam logic [7:0] ADDR_RESULT           = 8'h24;
	localparam logic [7:0] ADDR_FIFO_DATA        = 8'h28;
	localparam logic [7:0] ADDR_STATUS           = 8'h2C;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTL_CHANNEL_BIT     = 0;
	localparam int CTL_INV_ONE_BIT     = 1;
	localparam int CTL_INV_TWO_BIT     = 2;
	localparam int CTL_LEVEL_SHIFT_BIT = 3;
	localparam int CTL_TEMP_EXT_BIT    = 4;
	localparam int LOAD_STAGE1_BIT     = 0;
	localparam int LOAD_STAGE2_BIT     = 1;
	localparam int LOAD_TEMP_BIT       = 2;
	localparam int STAT_FIFO_VALID_BIT = 0;
	localparam int STAT_OVERRUN_BIT    = 1;
	localparam logic [4:0] CONTROL_RESET = 5'h00;
	localparam logic [1:0] OSR_RESET     = 2'h0;

	// ----------------------------------------------------------------
	// widths, ratios and code offsets
	// ----------------------------------------------------------------
	localparam int OFFSET_W = 10;
	localparam int TC_W     = 6;
	localparam int GAIN_W   = 5;
	localparam int PRESS_W  = 16;
	localparam int TEMP_W   = 10;
	localparam int STAGE1_RATIO = 32;
	localparam int TEMP_RATIO   = 1024;
	localparam logic signed [10:0] OFFSET_MID = 11'sh400;
	localparam logic signed [6:0]  TC_MID     = 7'sh40;
	localparam logic signed [17:0] PRESS_MAX  = 18'sh07FFF;
	localparam logic signed [11:0] TEMP_MAX   = 12'sh1FF;

	// per-sensor analog settings travel together
	typedef struct packed {
		logic                invert;
		logic [OFFSET_W-1:0] offset;
		logic [TC_W-1:0]     tc;
		logic [GAIN_W-1:0]   gain;
	} sdc_sensor_cfg_type;

endpackage

// File: rtl/sdc_top.sv
// Function
// - pressure bitstream is sampled at 1 MHz into the first decimator
// - first pressure stage decimates by 32, one sample per 32 us
// - second pressure stage decimates by 2, 4 or 8 per 2-bit field
// - final pressure result is a 16-bit signed word
// - result scales linearly: full negative -32768, full positive 32767
// - temperature bitstream at 128 kHz passes one decimator only
// - temperature decimator ratio is 1024, one result per 8 ms
// - temperature result is a 10-bit signed value
// - temperature input selectable between internal and external source
// - per-sensor polarity invert bits, channel select picks the applied one
// - offset setting is a 10-bit zero-order and 6-bit TC code
// - offset code 0..1023 drives the DAC as 2m+1-1024
// - two offset/TC pairs, channel select picks the applied pair
// - stage-2 gain has 32 steps
// - one gain per sensor, channel select picks the applied one
// - level-shift bit clear adds nothing, set subtracts 1.65 V
// - several load bits: stage one, then stage two, then temperature
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

module sdc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// honest flags straight from the fill count
	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem[rd_ptr_reg];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// storage needs no reset, pointers do
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data_i;
	end

	// pointer and fill count bookkeeping
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
					: wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
					: rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule

module sdc_top #(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        press_mod_clk_i,
	input  wire logic        press_mod_bit_i,
	input  wire logic        temp_mod_clk_i,
	input  wire logic        temp_mod_bit_i,
	output logic             polarity_invert_o,
	output logic [9:0]       offset_code_o,
	output logic [5:0]       offset_tc_code_o,
	output logic [10:0]      offset_dac_mult_o,
	output logic [6:0]       tc_dac_mult_o,
	output logic [4:0]       gain_code_o,
	output logic             level_shift_o,
	output logic             temp_source_external_o,
	output logic [15:0]      press_result_o,
	output logic             press_result_valid_o,
	output logic [9:0]       temp_result_o
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [4:0]  control_reg;
	logic [1:0]  osr_reg;
	logic [15:0] result_word_reg;
	logic        overrun_reg;
	sdc_pkg::sdc_sensor_cfg_type cfg_one_reg;
	sdc_pkg::sdc_sensor_cfg_type cfg_two_reg;
	sdc_pkg::sdc_sensor_cfg_type cfg_sel;
	logic [2:0]  p_sync_reg;
	logic [1:0]  pb_sync_reg;
	logic [2:0]  t_sync_reg;
	logic [1:0]  tb_sync_reg;
	logic        p_strobe;
	logic        t_strobe;
	logic [4:0]  s1_cnt_reg;
	logic [5:0]  s1_ones_reg;
	logic signed [6:0]  s1_out_reg;
	logic        s1_valid_reg;
	logic [2:0]  s2_cnt_reg;
	logic signed [9:0]  s2_acc_reg;
	logic signed [9:0]  s2_sum;
	logic signed [17:0] s2_scaled;
	logic [9:0]  t_cnt_reg;
	logic [10:0] t_ones_reg;
	logic signed [11:0] t_value;
	logic        t_valid_reg;
	logic        push_reg;
	logic        fifo_ready;
	logic        fifo_valid;
	logic [15:0] fifo_data;
	logic        acc_phase;
	logic        wr_en;
	logic        rd_take;
	logic        mapped;
	logic [31:0] rd_mux;
	logic [31:0] wr_image;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// apply byte strobes to a register image
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction

	// second-stage ratio minus one, value 3 folds onto ratio eight
	// osr decode
	function automatic logic [2:0] osr_last(input logic [1:0] oversampling_ratio_field);
		case (oversampling_ratio_field)
			2'h0:    osr_last = 3'h1;
			2'h1:    osr_last = 3'h3;
			default: osr_last = 3'h7;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// APB slave: one wait state, answer on the second access cycle
	// ----------------------------------------------------------------
	assign acc_phase = psel_i & penable_i;
	assign wr_en     = acc_phase & pready_o & pwrite_i & mapped;
	assign rd_take   = acc_phase & !pready_o & !pwrite_i;

	// decode shared by read mux and error answer
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr_i)
			sdc_pkg::ADDR_SENSOR_CONTROL:  rd_mux[4:0] = control_reg;
			sdc_pkg::ADDR_ONE_OFFSET_LOW:  rd_mux[9:0] = cfg_one_reg.offset;
			sdc_pkg::ADDR_ONE_OFFSET_HIGH:
				rd_mux[6:0] = {cfg_one_reg.invert, cfg_one_reg.tc};
			sdc_pkg::ADDR_TWO_OFFSET_LOW:  rd_mux[9:0] = cfg_two_reg.offset;
			sdc_pkg::ADDR_TWO_OFFSET_HIGH:
				rd_mux[6:0] = {cfg_two_reg.invert, cfg_two_reg.tc};
			sdc_pkg::ADDR_ONE_GAIN:        rd_mux[4:0] = cfg_one_reg.gain;
			sdc_pkg::ADDR_TWO_GAIN:        rd_mux[4:0] = cfg_two_reg.gain;
			sdc_pkg::ADDR_DECIMATOR_CTRL:  rd_mux[1:0] = osr_reg;
			sdc_pkg::ADDR_LOAD_REQUEST:    rd_mux = 32'h0000_0000;
			sdc_pkg::ADDR_RESULT:          rd_mux[15:0] = result_word_reg;
			sdc_pkg::ADDR_FIFO_DATA:
				rd_mux[15:0] = fifo_valid ? fifo_data : 16'h0000;
			sdc_pkg::ADDR_STATUS:
				rd_mux[1:0] = {overrun_reg, fifo_valid};
			default:                       mapped = 1'b0;
		endcase
	end

	// write image: byte lanes merged into the addressed register's readback
	assign wr_image = merge(rd_mux, pwdata_i, pstrb_i);

	// handshake and read capture; unmapped reads answer zero with error
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end
		else
		begin
			pready_o  <= acc_phase & !pready_o;
			pslverr_o <= acc_phase & !pready_o & !mapped;
			if (rd_take)
				prdata_o <= rd_mux;
		end
	end

	// software settings; untouched lanes keep the readback value
	// two invert bits kept
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			control_reg <= sdc_pkg::CONTROL_RESET;
			osr_reg     <= sdc_pkg::OSR_RESET;
			cfg_one_reg <= '0;
			cfg_two_reg <= '0;
		end
		else if (wr_en)
		begin
			case (paddr_i)
				sdc_pkg::ADDR_SENSOR_CONTROL:
					control_reg <= wr_image[4:0];
				sdc_pkg::ADDR_ONE_OFFSET_LOW:
					cfg_one_reg.offset <= wr_image[9:0];
				sdc_pkg::ADDR_TWO_OFFSET_LOW:
					cfg_two_reg.offset <= wr_image[9:0];
				sdc_pkg::ADDR_ONE_OFFSET_HIGH:
					cfg_one_reg.tc <= wr_image[5:0];
				sdc_pkg::ADDR_TWO_OFFSET_HIGH:
					cfg_two_reg.tc <= wr_image[5:0];
				sdc_pkg::ADDR_ONE_GAIN:
					cfg_one_reg.gain <= wr_image[4:0];
				sdc_pkg::ADDR_TWO_GAIN:
					cfg_two_reg.gain <= wr_image[4:0];
				sdc_pkg::ADDR_DECIMATOR_CTRL:
					osr_reg <= wr_image[1:0];
				default:
					osr_reg <= osr_reg;
			endcase
		end
		else
		begin
			// invert bits live in the control register
			cfg_one_reg.invert <= control_reg[sdc_pkg::CTL_INV_ONE_BIT];
			cfg_two_reg.invert <= control_reg[sdc_pkg::CTL_INV_TWO_BIT];
		end
	end

	// ----------------------------------------------------------------
	// analog settings for the selected sensor
	// ----------------------------------------------------------------
	// channel picks settings
	assign cfg_sel = control_reg[sdc_pkg::CTL_CHANNEL_BIT] ? cfg_two_reg
		: cfg_one_reg;

	// registered so the analog switches never see a decode glitch
	// offset and tc codes
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			polarity_invert_o      <= 1'b0;
			offset_code_o          <= 10'h000;
			offset_tc_code_o       <= 6'h00;
			offset_dac_mult_o      <= 11'h401;
			tc_dac_mult_o          <= 7'h41;
			gain_code_o            <= 5'h00;
			level_shift_o          <= 1'b0;
			temp_source_external_o <= 1'b0;
		end
		else
		begin
			polarity_invert_o <= cfg_sel.invert;
			offset_code_o     <= cfg_sel.offset;
			offset_tc_code_o  <= cfg_sel.tc;
			offset_dac_mult_o <= 11'({1'b0, cfg_sel.offset, 1'b1})
				- sdc_pkg::OFFSET_MID;
			tc_dac_mult_o     <= 7'({1'b0, cfg_sel.tc, 1'b1})
				- sdc_pkg::TC_MID;
			gain_code_o       <= cfg_sel.gain;
			level_shift_o     <= control_reg[sdc_pkg::CTL_LEVEL_SHIFT_BIT];
			temp_source_external_o <=
				control_reg[sdc_pkg::CTL_TEMP_EXT_BIT];
		end
	end

	// ----------------------------------------------------------------
	// modulator pins: two flops, then an edge detector on stage two
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			p_sync_reg  <= 3'h0;
			pb_sync_reg <= 2'h0;
			t_sync_reg  <= 3'h0;
			tb_sync_reg <= 2'h0;
		end
		else
		begin
			p_sync_reg  <= {p_sync_reg[1:0], press_mod_clk_i};
			pb_sync_reg <= {pb_sync_reg[0], press_mod_bit_i};
			t_sync_reg  <= {t_sync_reg[1:0], temp_mod_clk_i};
			tb_sync_reg <= {tb_sync_reg[0], temp_mod_bit_i};
		end
	end

	assign p_strobe = p_sync_reg[1] & !p_sync_reg[2];
	assign t_strobe = t_sync_reg[1] & !t_sync_reg[2];

	// ----------------------------------------------------------------
	// pressure stage one: count ones over 32 bits
	// ----------------------------------------------------------------
	// ratio of 32
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s1_cnt_reg   <= 5'h00;
			s1_ones_reg  <= 6'h00;
			s1_out_reg   <= 7'sh00;
			s1_valid_reg <= 1'b0;
		end
		else
		begin
			s1_valid_reg <= 1'b0;
			if (p_strobe)
			begin
				s1_cnt_reg <= s1_cnt_reg + 5'h01;
				if (s1_cnt_reg == 5'(sdc_pkg::STAGE1_RATIO - 1))
				begin
					// ones mapped to -32..+32 in one write
					s1_out_reg <= 7'({s1_ones_reg + 6'(pb_sync_reg[1]),
						1'b0}) - 7'sh20;
					s1_ones_reg  <= 6'h00;
					s1_valid_reg <= 1'b1;
				end
				else
					s1_ones_reg <= s1_ones_reg + 6'(pb_sync_reg[1]);
			end
		end
	end

	// ----------------------------------------------------------------
	// pressure stage two: sum 2, 4 or 8 stage-one samples
	// ----------------------------------------------------------------
	assign s2_sum = s2_acc_reg + 10'(s1_out_reg);

	always_comb
	begin
		case (osr_last(osr_reg))
			3'h1:    s2_scaled = 18'(s2_sum) <<< 9;
			3'h3:    s2_scaled = 18'(s2_sum) <<< 8;
			default: s2_scaled = 18'(s2_sum) <<< 7;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s2_cnt_reg           <= 3'h0;
			s2_acc_reg           <= 10'sh000;
			press_result_o       <= 16'h0000;
			press_result_valid_o <= 1'b0;
		end
		else
		begin
			press_result_valid_o <= 1'b0;
			if (s1_valid_reg)
			begin
				if (s2_cnt_reg >= osr_last(osr_reg))
				begin
					// only the top code saturates
					press_result_o <= (s2_scaled > sdc_pkg::PRESS_MAX)
						? 16'h7FFF : s2_scaled[15:0];
					press_result_valid_o <= 1'b1;
					s2_cnt_reg <= 3'h0;
					s2_acc_reg <= 10'sh000;
				end
				else
				begin
					s2_cnt_reg <= s2_cnt_reg + 3'h1;
					s2_acc_reg <= s2_sum;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// temperature decimator: ones over 1024 bits, less half the ratio, to 10 bits
	// ----------------------------------------------------------------
	// midscale is half the ratio, so the span fits ten signed bits except +512, which saturates to 511
	assign t_value = 12'({1'b0, t_ones_reg + 11'(tb_sync_reg[1])})
		- 12'(sdc_pkg::TEMP_RATIO / 2);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			t_cnt_reg     <= 10'h000;
			t_ones_reg    <= 11'h000;
			temp_result_o <= 10'h000;
			t_valid_reg   <= 1'b0;
		end
		else
		begin
			t_valid_reg <= 1'b0;
			if (t_strobe)
			begin
				t_cnt_reg <= t_cnt_reg + 10'h001;
				if (t_cnt_reg == 10'(sdc_pkg::TEMP_RATIO - 1))
				begin
					temp_result_o <= (t_value >= sdc_pkg::TEMP_MAX)
						? 10'h1FF : t_value[9:0];
					t_ones_reg  <= 11'h000;
					t_valid_reg <= 1'b1;
				end
				else
					t_ones_reg <= t_ones_reg + 11'(tb_sync_reg[1]);
			end
		end
	end

	// ----------------------------------------------------------------
	// pressure results buffered for software
	// ----------------------------------------------------------------
	// a full buffer holds the word back; a newer word replaces it
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			push_reg    <= 1'b0;
			overrun_reg <= 1'b0;
		end
		else
		begin
			if (press_result_valid_o)
				push_reg <= 1'b1;
			else if (fifo_ready)
				push_reg <= 1'b0;
			// set beats the clear-on-read of the status word
			if (press_result_valid_o && push_reg && !fifo_ready)
				overrun_reg <= 1'b1;
			else if (rd_take && paddr_i == sdc_pkg::ADDR_STATUS)
				overrun_reg <= 1'b0;
		end
	end

	sdc_fifo #(
		.WIDTH (sdc_pkg::PRESS_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (push_reg),
		.in_ready_o  (fifo_ready),
		.in_data_i   (press_result_o),
		.out_valid_o (fifo_valid),
		.out_ready_i (rd_take && paddr_i == sdc_pkg::ADDR_FIFO_DATA),
		.out_data_o  (fifo_data)
	);

	// ----------------------------------------------------------------
	// result word loaded on request, one source only
	// ----------------------------------------------------------------
	// fixed load priority
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			result_word_reg <= 16'h0000;
		else if (wr_en && paddr_i == sdc_pkg::ADDR_LOAD_REQUEST
			&& pstrb_i[0])
		begin
			if (pwdata_i[sdc_pkg::LOAD_STAGE1_BIT])
				result_word_reg <= 16'(s1_out_reg);
			else if (pwdata_i[sdc_pkg::LOAD_STAGE2_BIT])
				result_word_reg <= press_result_o;
			else if (pwdata_i[sdc_pkg::LOAD_TEMP_BIT])
				result_word_reg <= {{6{temp_result_o[9]}}, temp_result_o};
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_s1_period;
		@(posedge clk_i) disable iff (!rst_n_i)
		s1_valid_reg |-> s1_cnt_reg == 5'h00 && s1_ones_reg == 6'h00;
	endproperty
	a_s1_period: assert property (p_s1_period)
		else $error("stage one fired off its period");

	property p_s1_range;
		@(posedge clk_i) disable iff (!rst_n_i)
		s1_valid_reg |-> s1_out_reg >= -7'sd32 && s1_out_reg <= 7'sd32;
	endproperty
	a_s1_range: assert property (p_s1_range)
		else $error("stage one sample out of range");

	property p_s2_ratio;
		@(posedge clk_i) disable iff (!rst_n_i)
		press_result_valid_o && $past(osr_reg) == 2'h0
			|-> $past(s2_cnt_reg) == 3'h1;
	endproperty
	a_s2_ratio: assert property (p_s2_ratio)
		else $error("stage two ratio wrong");

	property p_press_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		!press_result_valid_o |-> $stable(press_result_o);
	endproperty
	a_press_hold: assert property (p_press_hold)
		else $error("pressure word changed mid period");

	property p_temp_period;
		@(posedge clk_i) disable iff (!rst_n_i)
		t_valid_reg |-> t_cnt_reg == 10'h000 ##1 !t_valid_reg;
	endproperty
	a_temp_period: assert property (p_temp_period)
		else $error("temperature result off its period");

	property p_invert_sel;
		@(posedge clk_i) disable iff (!rst_n_i)
		##1 polarity_invert_o == ($past(control_reg[0])
			? $past(cfg_two_reg.invert) : $past(cfg_one_reg.invert));
	endproperty
	a_invert_sel: assert property (p_invert_sel)
		else $error("wrong sensor invert applied");

	property p_gain_sel;
		@(posedge clk_i) disable iff (!rst_n_i)
		$stable(control_reg) && $stable(cfg_two_reg.gain)
			&& control_reg[0] ##1 1'b1 |-> gain_code_o == cfg_two_reg.gain;
	endproperty
	a_gain_sel: assert property (p_gain_sel)
		else $error("wrong sensor gain applied");

	property p_offset_mult;
		@(posedge clk_i) disable iff (!rst_n_i)
		$signed(offset_dac_mult_o)
			== $signed({1'b0, offset_code_o, 1'b1}) - 12'sd1024;
	endproperty
	a_offset_mult: assert property (p_offset_mult)
		else $error("offset multiplier mismatch");

	property p_load_prio;
		@(posedge clk_i) disable iff (!rst_n_i)
		wr_en && paddr_i == 8'h20 && pstrb_i[0] && pwdata_i[0]
			|=> result_word_reg == 16'($past(s1_out_reg));
	endproperty
	a_load_prio: assert property (p_load_prio)
		else $error("load priority broken");
endmodule

// File: verification/sdc_cpu_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// processor model: apb master for results
// ----------------------------------------
module sdc_cpu_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	output logic [7:0]       paddr_o,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [31:0]      pwdata_o,
	output logic [3:0]       pstrb_o
);
	// bus idle from time zero
	initial
	begin
		paddr_o = 8'h00;
		psel_o = 1'h0;
		penable_o = 1'h0;
		pwrite_o = 1'h0;
		pwdata_o = 32'h0;
		pstrb_o = 4'hF;
	end

	// one transfer; pready is awaited, the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk_i);
		paddr_o <= a;
		pwrite_o <= w;
		pwdata_o <= d;
		psel_o <= 1'h1;
		@(posedge clk_i);
		penable_o <= 1'h1;
		@(posedge clk_i);
		while (pready_i !== 1'h1)
			@(posedge clk_i);
		q = prdata_i;
		e = pslverr_i;
		psel_o <= 1'h0;
		penable_o <= 1'h0;
	endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns

module testbench;
	logic        clk_i, rst_n_i, psel, pen, pwr, prdy, perr, pval;
	logic        pclk, pbit, tclk, tbit, inv, lsh, ext;
	logic [7:0]  pa;
	logic [31:0] pwd, prd, q;
	logic [3:0]  pst;
	logic [9:0]  ofs, tres;
	logic [5:0]  tcc;
	logic [10:0] odm;
	logic [6:0]  tdm;
	logic [4:0]  gn;
	logic [15:0] pres;
	logic        e;
	int          error_cnt, check_count, ones1, cnt1, onest, oversampling_ratio_field, c2, sum;
	int          last1, pi, kp, kt, te, ctl, j;
	int          xq[$];
	int          o[2], t[2], g[2];

	// --------------------------------
	// clock, partner and design
	// --------------------------------
	initial
		clk_i = 1'h0;
	always #50 clk_i = ~clk_i;

	sdc_cpu_model u_cpu (.clk_i(clk_i), .prdata_i(prd), .pready_i(prdy),
		.pslverr_i(perr), .paddr_o(pa), .psel_o(psel), .penable_o(pen),
		.pwrite_o(pwr), .pwdata_o(pwd), .pstrb_o(pst));

	// small fifo so eight results overflow it
	sdc_top #(.FIFO_DEPTH(4)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.paddr_i(pa), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.pwdata_i(pwd), .pstrb_i(pst), .prdata_o(prd), .pready_o(prdy),
		.pslverr_o(perr), .press_mod_clk_i(pclk), .press_mod_bit_i(pbit),
		.temp_mod_clk_i(tclk), .temp_mod_bit_i(tbit),
		.polarity_invert_o(inv), .offset_code_o(ofs),
		.offset_tc_code_o(tcc), .offset_dac_mult_o(odm),
		.tc_dac_mult_o(tdm), .gain_code_o(gn), .level_shift_o(lsh),
		.temp_source_external_o(ext), .press_result_o(pres),
		.press_result_valid_o(pval), .temp_result_o(tres));

	task automatic chk(input string n, input logic [31:0] x, g);
		check_count++;
		if (g !== x)
		begin
			$display("BAD %s expected %h seen %h", n, x, g);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_cpu.xfer(1'h1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a);
		u_cpu.xfer(1'h0, a, 32'h0, q, e);
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one modulator strobe on both channels, reference model alongside
	task automatic step(input logic pb, tb);
		pclk <= 1'h1;
		tclk <= 1'h1;
		pbit <= pb;
		tbit <= tb;
		ones1 += pb;
		onest += tb;
		cnt1++;
		if (cnt1 == 32)
		begin
			last1 = 2 * ones1 - 32;
			sum += last1;
			c2++;
			cnt1 = 0;
			ones1 = 0;
			if (c2 >= (oversampling_ratio_field == 0 ? 2 : oversampling_ratio_field == 1 ? 4 : 8))
			begin
				xq.push_back((sum * 1024 / c2 > 32767) ? 32767 : sum * 1024 / c2);
				sum = 0;
				c2 = 0;
			end
		end
		repeat (3) @(posedge clk_i);
		pclk <= 1'h0;
		tclk <= 1'h0;
		repeat (3) @(posedge clk_i);
	endtask

	// every pressure result against the model queue
	always @(posedge clk_i)
		if (pval === 1'h1)
		begin
			chk("press", (pi < xq.size()) ? {16'h0, 16'(xq[pi])}
				: 32'hF_0000, {16'h0, pres});
			pi++;
		end

	// watchdog cuts a hang short
	initial
	begin
		#(100 * 20000);
		error_cnt++;
		give_verdict();
	end

	// main sequence
	initial
	begin
		{rst_n_i, pclk, pbit, tclk, tbit} = 5'h00;
		void'($urandom(32'h4225));
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		chk("odm0", 32'h401, odm);
		chk("tdm0", 32'h41, tdm);
		for (int s = 0; s < 2; s++)
		begin
			o[s] = $urandom % 1024;
			t[s] = $urandom % 64;
			g[s] = $urandom % 32;
			wr(8'h04 + 8'(8 * s), o[s]);
			wr(8'h08 + 8'(8 * s), t[s]);
			wr(8'h14 + 8'(4 * s), g[s]);
		end
		for (int s = 0; s < 2; s++)
		begin
			ctl = ($urandom % 32) & 30 | s;
			wr(8'h00, ctl);
			repeat (3) @(posedge clk_i);
			chk("inv", ctl[1 + s], inv);
			chk("ofs", o[s], ofs);
			chk("odm", {21'h0, 11'(2 * o[s] + 1 - 1024)}, odm);
			chk("tdm", {25'h0, 7'(2 * t[s] + 1 - 64)}, tdm);
			chk("tcc", t[s], tcc);
			chk("gain", g[s], gn);
			chk("lsh", ctl[3], lsh);
			chk("ext", ctl[4], ext);
		end
		rd(8'h3C);
		chk("err", 32'h1, e);
		chk("errq", 32'h0, q);
		kt = $urandom % 9;
		for (oversampling_ratio_field = 0; oversampling_ratio_field < 4; oversampling_ratio_field++)
		begin
			wr(8'h1C, oversampling_ratio_field);
			kp = (oversampling_ratio_field == 0) ? 8 : (oversampling_ratio_field == 1) ? 0 : $urandom % 9;
			repeat (256) step(($urandom % 8) < kp, ($urandom % 8) < kt);
		end
		repeat (20) @(posedge clk_i);
		chk("count", xq.size(), pi);
		te = (onest - 512 > 511) ? 511 : onest - 512;
		chk("temp", {22'h0, 10'(te)}, tres);
		wr(8'h20, 32'h7);
		rd(8'h24);
		chk("load1", {16'h0, 16'(last1)}, q[15:0]);
		wr(8'h20, 32'h6);
		rd(8'h24);
		chk("load2", {16'h0, 16'(xq[7])}, q[15:0]);
		wr(8'h20, 32'h4);
		rd(8'h24);
		chk("loadt", {16'h0, 16'(te)}, q[15:0]);
		rd(8'h2C);
		chk("stat", 32'h3, q);
		for (int i = 0; i < 5; i++)
		begin
			j = (i < 4) ? i : 7;
			rd(8'h28);
			chk("fifo", {16'h0, 16'(xq[j])}, q[15:0]);
		end
		rd(8'h2C);
		chk("stat", 32'h0, q);
		give_verdict();
	end
endmodule
